// file: hdl/exec_core.sv
// flag-setting execution unit with conditional branch, pc-relative address and immediate load/store
// Function
// - flags an instruction does not update keep their previous value
// - branches use flags of the latest flag-updating instruction
// - negative and zero flags follow the result sign and zero test
// - addition carry set when unbounded sum reaches two to the 32
// - subtraction carry set when no borrow; shifts also produce carry
// - overflow set when result sign differs from infinitely precise sign
// - compare acts as subtraction, compare-negative as addition, no result written
// - conditional branch taken only when flags satisfy condition, else no effect
// - single-flag conditions test zero, carry, negative or overflow directly
// - higher is carry and not zero; lower-or-same is no carry or zero
// - signed conditions compare negative with overflow, less-or-equal as printed
// - branch with no suffix or always suffix is always taken
// - pc-relative address adds immediate to program counter into destination
// - pc-relative destination low register, target word aligned within 1020 bytes
// - pc-relative address leaves all flags unchanged
// - byte and halfword loads zero-extend; word loads write unchanged
// - stores write whole word, low byte or low halfword
// - effective address is base plus immediate, missing immediate is zero
// - immediate ranges: 1020/4 sp word, 124/4 word, 62/2 half, 31 byte
// - data and base registers low only; stack pointer base for words
// - effective address must be multiple of transfer size
// - immediate loads and stores leave all flags unchanged
// - unaligned access not performed, hard fault raised instead
// - pc value used is current instruction address plus four
`timescale 1ns/10ps
module exec_core
	import exec_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              pclk,       // bus clock, 50 MHz
	input  wire logic              presetn,    // asynchronous reset, active low
	input  wire logic              psel,       // apb select
	input  wire logic              penable,    // apb enable
	input  wire logic              pwrite,     // apb direction
	input  wire logic [ADDR_W-1:0] paddr,      // apb byte address
	input  wire logic [31:0]       pwdata,     // apb write data
	output logic      [31:0]       prdata,     // apb read data
	output logic                   pready,     // apb ready
	output logic                   pslverr,    // apb error, unmapped address
	output mem_req_s               mem_req,    // memory request fields
	output logic                   mem_valid,  // memory request pending
	input  wire logic              mem_ack,    // memory request accepted this cycle
	input  wire logic [31:0]       mem_rdata,  // load data, right-justified
	output logic                   hard_fault  // one-cycle hard_fault_exception pulse
);

	if (ADDR_W < 7) begin : g_chk
		$error("exec_core: ADDR_W must be at least 7");
	end

	typedef enum logic [1:0] {st_idle, st_exec, st_mem} state_e;

	state_e      state_q;
	logic [31:0] cmd_q;
	logic [31:0] regs_q [LOW_REGS];
	logic [31:0] sp_q;
	logic [31:0] pc_q;
	flags_s      flags_q;
	logic [31:0] result_q;
	logic        taken_q;
	logic        fault_q;
	logic        refused_q;
	logic        pready_q;
	logic [31:0] prdata_q;
	logic        pslverr_q;
	mem_req_s    mem_req_q;
	logic        mem_valid_q;
	logic        hard_fault_q;
	logic [REG_IDX_W-1:0] mem_rd_q;

	function automatic alu_s add_op(input logic [31:0] a, input logic [31:0] b, input logic cin);
		logic [32:0] s;
		alu_s        r;
		s = {1'b0, a} + {1'b0, b} + {32'h0, cin};
		r.res = s[31:0];
		r.f.n = s[31];
		r.f.z = (s[31:0] == 32'h0);
		r.f.c = s[32];
		r.f.v = (a[31] == b[31]) && (s[31] != a[31]);
		return r;
	endfunction : add_op

	function automatic logic cond_pass(input cond_e cc, input flags_s f);
		logic p;
		unique case (cc)
			cc_eq:   p = f.z;
			cc_ne:   p = !f.z;
			cc_hs:   p = f.c;
			cc_lo:   p = !f.c;
			cc_mi:   p = f.n;
			cc_pl:   p = !f.n;
			cc_vs:   p = f.v;
			cc_vc:   p = !f.v;
			cc_hi:   p = f.c && !f.z;
			cc_ls:   p = !f.c || f.z;
			cc_ge:   p = (f.n == f.v);
			cc_lt:   p = (f.n != f.v);
			cc_gt:   p = !f.z && (f.n == f.v);
			cc_le:   p = f.z && (f.n != f.v);
			cc_al,
			cc_none: p = 1'b1;
		endcase
		return p;
	endfunction : cond_pass

	function automatic logic [31:0] zero_extend(input size_e sz, input logic [31:0] d);
		logic [31:0] r;
		unique case (sz)
			sz_byte: r = {24'h0, d[7:0]};
			sz_half: r = {16'h0, d[15:0]};
			default: r = d;
		endcase
		return r;
	endfunction : zero_extend

	// command field decode
	logic [4:0]           op_raw;
	op_e                  op;
	cond_e                cc;
	logic [REG_IDX_W-1:0] rd;
	logic [REG_IDX_W-1:0] rn;
	logic [REG_IDX_W-1:0] rm;
	logic                 base_sp;
	logic [CMD_IMM_W-1:0] imm;

	assign op_raw  = cmd_q[CMD_OP_LSB +: CMD_OP_W];
	assign op      = op_e'(op_raw);
	assign cc      = cond_e'(cmd_q[CMD_COND_LSB +: CMD_COND_W]);
	assign rd      = cmd_q[CMD_RD_LSB +: REG_IDX_W];
	assign rn      = cmd_q[CMD_RN_LSB +: REG_IDX_W];
	assign rm      = cmd_q[CMD_RM_LSB +: REG_IDX_W];
	assign base_sp = cmd_q[CMD_SP_BIT];
	assign imm     = cmd_q[CMD_IMM_LSB +: CMD_IMM_W];

	// execute-stage decisions
	logic [31:0] imm32;
	logic [31:0] pc_ahead;
	logic [31:0] base;
	logic [31:0] eff_addr;
	alu_s        alu;
	logic        rd_we;
	logic        flags_we;
	logic        go_mem;
	logic        bad;
	logic        misaligned;
	logic        taken;
	size_e       sz;
	logic        is_store;
	logic [32:0] sh;

	assign imm32    = {22'h0, imm};
	assign pc_ahead = pc_q + PC_AHEAD;
	assign base     = base_sp ? sp_q : regs_q[rn];
	assign eff_addr = base + imm32;

	always_comb begin
		alu        = '0;
		rd_we      = 1'b0;
		flags_we   = 1'b0;
		go_mem     = 1'b0;
		bad        = 1'b0;
		misaligned = 1'b0;
		taken      = 1'b0;
		sz         = sz_word;
		is_store   = 1'b0;
		sh         = '0;
		alu.f      = flags_q;
		unique case (op)
			op_nop: begin
			end
			op_add_s, op_compare_negative: begin
				alu      = add_op(regs_q[rn], regs_q[rm], 1'b0);
				flags_we = 1'b1;
				rd_we    = (op == op_add_s);
			end
			op_sub_s, op_compare: begin
				alu      = add_op(regs_q[rn], ~regs_q[rm], 1'b1);
				flags_we = 1'b1;
				rd_we    = (op == op_sub_s);
			end
			op_shl_s: begin
				sh        = {1'b0, regs_q[rn]} << imm[4:0];
				alu.res   = sh[31:0];
				alu.f.n   = sh[31];
				alu.f.z   = (sh[31:0] == 32'h0);
				alu.f.c   = (imm[4:0] == 5'h0) ? flags_q.c : sh[32];
				flags_we  = 1'b1;
				rd_we     = 1'b1;
			end
			op_shr_s: begin
				sh        = {regs_q[rn], 1'b0} >> imm[4:0];
				alu.res   = sh[32:1];
				alu.f.n   = sh[32];
				alu.f.z   = (sh[32:1] == 32'h0);
				alu.f.c   = (imm[4:0] == 5'h0) ? flags_q.c : sh[0];
				flags_we  = 1'b1;
				rd_we     = 1'b1;
			end
			op_branch: begin
				taken = cond_pass(cc, flags_q);
			end
			op_pc_addr: begin
				alu.res = pc_ahead + imm32;
				bad     = (imm > PC_ADDR_MAX) || (imm[1:0] != 2'b00)
				          || (alu.res[1:0] != 2'b00);
				rd_we   = !bad;
			end
			op_word_load, op_word_store: begin
				sz       = sz_word;
				is_store = (op == op_word_store);
				bad      = base_sp ? (imm > WORD_SP_MAX) : (imm > WORD_LOW_MAX);
				bad      = bad || (imm[1:0] != 2'b00);
				go_mem   = 1'b1;
			end
			op_halfword_load, op_halfword_store: begin
				sz       = sz_half;
				is_store = (op == op_halfword_store);
				bad      = base_sp || (imm > HALF_MAX) || imm[0];
				go_mem   = 1'b1;
			end
			op_byte_load, op_byte_store: begin
				sz       = sz_byte;
				is_store = (op == op_byte_store);
				bad      = base_sp || (imm > BYTE_MAX);
				go_mem   = 1'b1;
			end
			default: begin
				bad = 1'b1;
			end
		endcase
		if (go_mem && !bad) begin
			unique case (sz)
				sz_word: misaligned = (eff_addr[1:0] != 2'b00);
				sz_half: misaligned = eff_addr[0];
				default: misaligned = 1'b0;
			endcase
		end
	end

	// apb decode
	logic [7:0]  off;
	logic        hit;
	logic [31:0] rdata_c;
	logic        idle;
	logic        wr_fire;
	logic        in_regs;

	assign off     = paddr[7:0];
	assign idle    = (state_q == st_idle);
	assign wr_fire = psel && penable && pready_q && pwrite && !pslverr_q;
	assign in_regs = (off >= OFF_REG_BASE) && (off <= OFF_REG_LAST);

	always_comb begin
		hit     = 1'b1;
		rdata_c = 32'h0;
		if ((paddr[ADDR_W-1:8 > ADDR_W-1 ? ADDR_W-1 : 8] != '0 && ADDR_W > 8) || off[1:0] != 2'b00) begin
			hit = 1'b0;
		end else if (in_regs) begin
			rdata_c = regs_q[off[4:2]];
		end else begin
			unique case (off)
				OFF_CMD:    rdata_c = cmd_q;
				OFF_FLAGS:  rdata_c = {flags_q, 28'h0};
				OFF_PC:     rdata_c = pc_q;
				OFF_STATUS: rdata_c = {28'h0, refused_q, fault_q, taken_q, !idle};
				OFF_RESULT: rdata_c = result_q;
				OFF_SP:     rdata_c = sp_q;
				default:    hit     = 1'b0;
			endcase
		end
	end

	// ready one cycle into the access phase, data and error registered with it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0;
			pslverr_q <= 1'b0;
		end else if (psel && penable && !pready_q) begin
			pready_q  <= 1'b1;
			prdata_q  <= pwrite ? 32'h0 : rdata_c;
			pslverr_q <= !hit;
		end else begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	// sequencing: a command write while idle starts one instruction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= st_idle;
			cmd_q   <= 32'h0;
		end else begin
			unique case (state_q)
				st_idle: begin
					if (wr_fire && off == OFF_CMD) begin
						cmd_q   <= pwdata;
						state_q <= st_exec;
					end
				end
				st_exec: begin
					state_q <= (go_mem && !bad && !misaligned) ? st_mem : st_idle;
				end
				st_mem: begin
					if (mem_ack) begin
						state_q <= st_idle;
					end
				end
			endcase
		end
	end

	// low register file and stack pointer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < LOW_REGS; i++) begin
				regs_q[i] <= REG_RESET;
			end
			sp_q <= SP_RESET;
		end else if (idle && wr_fire && in_regs) begin
			regs_q[off[4:2]] <= pwdata;
		end else if (idle && wr_fire && off == OFF_SP) begin
			sp_q <= pwdata;
		end else if (state_q == st_exec && rd_we) begin
			regs_q[rd] <= alu.res;
		end else if (state_q == st_mem && mem_ack && !mem_req_q.we) begin
			regs_q[mem_rd_q] <= zero_extend(mem_req_q.size, mem_rdata);
		end
	end

	// program_status_word flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_q <= FLAGS_RESET;
		end else if (idle && wr_fire && off == OFF_FLAGS) begin
			flags_q <= flags_s'(pwdata[FLAGS_LSB +: 4]);
		end else if (state_q == st_exec && flags_we) begin
			flags_q <= alu.f;
		end
	end

	// program counter: advance one instruction, or to the branch target
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_q <= PC_RESET;
		end else if (idle && wr_fire && off == OFF_PC) begin
			pc_q <= pwdata;
		end else if (state_q == st_exec && !bad && !misaligned) begin
			pc_q <= taken ? pc_ahead + {{21{imm[9]}}, imm, 1'b0} : pc_q + INSN_BYTES;
		end
	end

	// result and outcome status of the last instruction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_q  <= 32'h0;
			taken_q   <= 1'b0;
			fault_q   <= 1'b0;
			refused_q <= 1'b0;
		end else if (state_q == st_exec) begin
			result_q  <= go_mem ? eff_addr : alu.res;
			taken_q   <= taken;
			fault_q   <= !bad && misaligned;
			refused_q <= bad;
		end else if (state_q == st_mem && mem_ack && !mem_req_q.we) begin
			result_q <= zero_extend(mem_req_q.size, mem_rdata);
		end
	end

	// memory request held until accepted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_req_q   <= '0;
			mem_valid_q <= 1'b0;
			mem_rd_q    <= '0;
		end else if (state_q == st_exec && go_mem && !bad && !misaligned) begin
			mem_req_q.addr  <= eff_addr;
			mem_req_q.wdata <= is_store ? zero_extend(sz, regs_q[rd]) : 32'h0;
			mem_req_q.we    <= is_store;
			mem_req_q.size  <= sz;
			mem_valid_q     <= 1'b1;
			mem_rd_q        <= rd;
		end else if (mem_ack) begin
			mem_valid_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hard_fault_q <= 1'b0;
		end else begin
			hard_fault_q <= (state_q == st_exec) && !bad && misaligned;
		end
	end

	assign prdata     = prdata_q;
	assign pready     = pready_q;
	assign pslverr    = pslverr_q;
	assign mem_req    = mem_req_q;
	assign mem_valid  = mem_valid_q;
	assign hard_fault = hard_fault_q;

endmodule : exec_core

// file: shared/exec_pkg.sv
// package: encodings, field layout, offsets and limits of the flag and load/store execution unit
package exec_pkg;

	typedef enum logic [4:0] {
		op_nop,
		op_add_s,
		op_sub_s,
		op_compare,
		op_compare_negative,
		op_shl_s,
		op_shr_s,
		op_branch,
		op_pc_addr,
		op_word_load,
		op_halfword_load,
		op_byte_load,
		op_word_store,
		op_halfword_store,
		op_byte_store
	} op_e;

	typedef enum logic [3:0] {
		cc_eq, cc_ne, cc_hs, cc_lo, cc_mi, cc_pl, cc_vs, cc_vc,
		cc_hi, cc_ls, cc_ge, cc_lt, cc_gt, cc_le, cc_al, cc_none
	} cond_e;

	typedef enum logic [1:0] {sz_byte, sz_half, sz_word} size_e;

	typedef struct packed {
		logic n;
		logic z;
		logic c;
		logic v;
	} flags_s;

	typedef struct packed {
		logic [31:0] res;
		flags_s      f;
	} alu_s;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic        we;
		size_e       size;
	} mem_req_s;

	// command word layout
	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_OP_W     = 5;
	localparam int CMD_COND_LSB = 5;
	localparam int CMD_COND_W   = 4;
	localparam int CMD_RD_LSB   = 9;
	localparam int CMD_RN_LSB   = 12;
	localparam int CMD_RM_LSB   = 15;
	localparam int CMD_SP_BIT   = 18;
	localparam int CMD_IMM_LSB  = 19;
	localparam int CMD_IMM_W    = 10;
	localparam int REG_IDX_W    = 3;
	localparam int LOW_REGS     = 8;

	// register offsets (byte addresses)
	localparam logic [7:0] OFF_CMD      = 8'h00;
	localparam logic [7:0] OFF_FLAGS    = 8'h04;
	localparam logic [7:0] OFF_PC       = 8'h08;
	localparam logic [7:0] OFF_STATUS   = 8'h0c;
	localparam logic [7:0] OFF_RESULT   = 8'h10;
	localparam logic [7:0] OFF_REG_BASE = 8'h40;
	localparam logic [7:0] OFF_REG_LAST = 8'h5c;
	localparam logic [7:0] OFF_SP       = 8'h60;

	// program_status_word field position (n,z,c,v from high to low)
	localparam int FLAGS_LSB = 28;

	// status register bits
	localparam int ST_BUSY    = 0;
	localparam int ST_TAKEN   = 1;
	localparam int ST_FAULT   = 2;
	localparam int ST_REFUSED = 3;

	// reset values
	localparam logic [31:0] PC_RESET    = 32'h0000_0000;
	localparam logic [31:0] SP_RESET    = 32'h0000_0000;
	localparam logic [31:0] REG_RESET   = 32'h0000_0000;
	localparam flags_s      FLAGS_RESET = '0;

	// offsets and limits
	localparam logic [31:0] PC_AHEAD       = 32'h0000_0004;
	localparam logic [31:0] INSN_BYTES     = 32'h0000_0002;
	localparam logic [9:0]  PC_ADDR_MAX    = 10'h3fc;
	localparam logic [9:0]  WORD_SP_MAX    = 10'h3fc;
	localparam logic [9:0]  WORD_LOW_MAX   = 10'h07c;
	localparam logic [9:0]  HALF_MAX       = 10'h03e;
	localparam logic [9:0]  BYTE_MAX       = 10'h01f;

endpackage : exec_pkg

// file: verification/exec_core_chk.sv
// checker: port-level timing of the bus, memory request and fault outputs
`timescale 1ns/10ps
module exec_core_chk
	import exec_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic              pclk,       // clock
	input wire logic              presetn,    // reset, active low
	input wire logic              psel,       // select
	input wire logic              penable,    // enable
	input wire logic              pwrite,     // direction
	input wire logic [ADDR_W-1:0] paddr,      // address
	input wire logic [31:0]       pwdata,     // write data
	input wire logic [31:0]       prdata,     // read data
	input wire logic              pready,     // ready
	input wire logic              pslverr,    // error
	input wire mem_req_s          mem_req,    // request fields
	input wire logic              mem_valid,  // request pending
	input wire logic              mem_ack,    // request accepted
	input wire logic [31:0]       mem_rdata,  // load data
	input wire logic              hard_fault  // fault pulse
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence

	property p_ready_second;
		s_setup ##1 s_access |-> !pready ##1 pready;
	endproperty
	a_ready_second: assert property (p_ready_second) else $error("pready not in second cycle");
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
	property p_unaligned;
		s_access ##0 pready && paddr[1:0] != 2'h0 |-> pslverr;
	endproperty
	a_unaligned: assert property (p_unaligned) else $error("no error on unaligned address");
	property p_req_hold;
		mem_valid && !mem_ack |=> mem_valid && $stable(mem_req);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request dropped or changed");
	property p_req_done;
		mem_valid && mem_ack |=> !mem_valid;
	endproperty
	a_req_done: assert property (p_req_done) else $error("second request for one command");
	property p_fault_pulse;
		hard_fault |=> !hard_fault;
	endproperty
	a_fault_pulse: assert property (p_fault_pulse) else $error("fault longer than one cycle");
	property p_fault_no_req;
		hard_fault |-> !mem_valid [*2];
	endproperty
	a_fault_no_req: assert property (p_fault_no_req) else $error("access made on fault");
	property p_align;
		mem_valid |-> (mem_req.size != sz_word || mem_req.addr[1:0] == 2'h0)
			&& (mem_req.size != sz_half || mem_req.addr[0] == 1'b0);
	endproperty
	a_align: assert property (p_align) else $error("unaligned memory request");
	property p_lanes;
		mem_valid && mem_req.we |-> (mem_req.size != sz_byte || mem_req.wdata[31:8] == 24'h0)
			&& (mem_req.size != sz_half || mem_req.wdata[31:16] == 16'h0);
	endproperty
	a_lanes: assert property (p_lanes) else $error("store data beyond its size");
	property p_size;
		mem_valid |-> mem_req.size inside {sz_byte, sz_half, sz_word};
	endproperty
	a_size: assert property (p_size) else $error("illegal transfer size");
endmodule : exec_core_chk

bind exec_core exec_core_chk #(.ADDR_W(ADDR_W)) i_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
	.mem_valid(mem_valid), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .hard_fault(hard_fault));

// file: verification/exec_core_tb.sv
// testbench: flags, conditions, pc-relative address and memory access over the register bus
`timescale 1ns/10ps
`define CHK(nm, e, g) \
	begin \
		checked++; \
		if ((g) !== (e)) begin \
			err_total++; \
			$display("MISMATCH %s expected %h seen %h", nm, (e), (g)); \
		end \
	end
module exec_core_tb
	import exec_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_v;
	logic        mem_valid, mem_ack, hard_fault;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, mem_rdata, rd_v, st_v, pc;
	logic [3:0]  ack_delay;
	mem_req_s    mem_req, last_req;
	flags_s      f;
	int          acc_n, err_total = 0, checked = 0, faults = 0;
	logic [7:0]  rst_a[5] = '{OFF_FLAGS, OFF_PC, OFF_SP, OFF_REG_BASE, OFF_STATUS};

	exec_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mem_req(mem_req), .mem_valid(mem_valid), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .hard_fault(hard_fault));
	mem_model i_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_valid(mem_valid),
		.ack_delay(ack_delay), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .acc_n(acc_n),
		.last_req(last_req));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		if (hard_fault === 1'b1) faults++;
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : stop_test

	// one idle cycle before each setup keeps every signal to one change per step
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd_v    = prdata;
		err_v   = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			err_total++;
			stop_test();
		end
	endtask : apb

	task automatic exec(logic [31:0] c);
		int n;
		n = 0;
		apb(1'b1, OFF_CMD, c);
		do begin
			apb(1'b0, OFF_STATUS, 32'h0);
			n++;
		end while (rd_v[ST_BUSY] !== 1'b0 && n < 40);
		st_v = rd_v;
		if (n >= 40) begin
			err_total++;
			stop_test();
		end
	endtask : exec

	function automatic logic [31:0] cmd(op_e op, cond_e cc, int rd, int rn, int rm, int sp,
		int imm);
		return {3'h0, imm[9:0], sp[0], rm[2:0], rn[2:0], rd[2:0], cc, op};
	endfunction : cmd

	function automatic logic [7:0] reg_a(int i);
		return OFF_REG_BASE + 8'(i * 4);
	endfunction : reg_a

	function automatic logic [31:0] mask(size_e sz, logic [31:0] v);
		return sz == sz_byte ? {24'h0, v[7:0]} : sz == sz_half ? {16'h0, v[15:0]} : v;
	endfunction : mask

	function automatic logic cond_ok(logic [3:0] cc, flags_s g);
		logic [15:0] t;
		t = {2'b11, g.z && g.n != g.v, !g.z && g.n == g.v, g.n != g.v, g.n == g.v,
			!g.c || g.z, g.c && !g.z, !g.v, g.v, !g.n, g.n, !g.c, g.c, !g.z, g.z};
		return t[cc];
	endfunction : cond_ok

	task automatic alu(op_e op, logic [31:0] a, logic [31:0] b, int imm, logic [3:0] pre,
		logic [31:0] res, logic [3:0] fl);
		apb(1'b1, OFF_FLAGS, {pre, 28'h0});
		apb(1'b1, reg_a(1), a);
		apb(1'b1, reg_a(2), b);
		apb(1'b1, reg_a(3), 32'h5a5a_5a5a);
		exec(cmd(op, cc_al, 3, 1, 2, 0, imm));
		apb(1'b0, reg_a(3), 32'h0);
		`CHK("alu result", res, rd_v)
		apb(1'b0, OFF_FLAGS, 32'h0);
		`CHK("alu flags", fl, rd_v[31:28])
	endtask : alu

	task automatic mem(op_e op, int sp, int imm, int bad, logic [31:0] ea, size_e sz);
		int n0;
		int f0;
		n0 = acc_n;
		f0 = faults;
		ack_delay <= 4'(imm % 4);
		apb(1'b1, reg_a(4), 32'hcafe_b1e7);
		exec(cmd(op, cc_al, 4, 1, 0, sp, imm));
		apb(1'b0, reg_a(4), 32'h0);
		if (bad != 0) begin
			`CHK("access count", n0, acc_n)
			`CHK("refused or faulted", 1'b1, st_v[bad])
			`CHK("fault pulses", f0 + (bad == ST_FAULT), faults)
		end else begin
			`CHK("address", ea, last_req.addr)
			`CHK("size", sz, last_req.size)
			`CHK("direction", op >= op_word_store, last_req.we)
			if (last_req.we === 1'b1) begin
				`CHK("store data", mask(sz, 32'hcafe_b1e7), last_req.wdata)
			end else begin
				`CHK("load data", mask(sz, ~ea ^ 32'h3c00_0000), rd_v)
			end
		end
	endtask : mem

	initial begin
		presetn   = 1'b0;
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = 8'h00;
		pwdata    = 32'h0;
		ack_delay = 4'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rst_a[i]) begin
			apb(1'b0, rst_a[i], 32'h0);
			`CHK("reset value", 32'h0, rd_v)
		end
		apb(1'b0, 8'h20, 32'h0);
		`CHK("unmapped error", 1'b1, err_v)
		`CHK("unmapped data", 32'h0, rd_v)
		apb(1'b1, 8'h05, 32'h1);
		`CHK("unaligned error", 1'b1, err_v)
		$display("test registers done");
		alu(op_add_s, 32'h7fff_ffff, 32'h1, 0, 4'h0, 32'h8000_0000, 4'h9);
		alu(op_add_s, 32'hffff_ffff, 32'h1, 0, 4'h9, 32'h0, 4'h6);
		alu(op_add_s, 32'h8000_0000, 32'h8000_0000, 0, 4'h0, 32'h0, 4'h7);
		alu(op_sub_s, 32'h5, 32'h5, 0, 4'h9, 32'h0, 4'h6);
		alu(op_sub_s, 32'h3, 32'h5, 0, 4'h6, 32'hffff_fffe, 4'h8);
		alu(op_sub_s, 32'h8000_0000, 32'h1, 0, 4'h0, 32'h7fff_ffff, 4'h3);
		alu(op_compare, 32'h3, 32'h5, 0, 4'h6, 32'h5a5a_5a5a, 4'h8);
		alu(op_compare_negative, 32'hffff_ffff, 32'h1, 0, 4'h9, 32'h5a5a_5a5a, 4'h6);
		alu(op_shl_s, 32'h8000_0001, 32'h0, 1, 4'h1, 32'h2, 4'h3);
		alu(op_shl_s, 32'h1, 32'h0, 0, 4'h3, 32'h1, 4'h3);
		alu(op_shr_s, 32'h3, 32'h0, 1, 4'h0, 32'h1, 4'h2);
		$display("test flags done");
		apb(1'b1, OFF_PC, 32'h200);
		pc = 32'h200;
		for (int i = 0; i < 256; i++) begin
			f = flags_s'(i[7:4]);
			apb(1'b1, OFF_FLAGS, {f, 28'h0});
			exec(cmd(op_branch, cond_e'(i[3:0]), 0, 0, 0, 0, 6));
			`CHK("taken", cond_ok(i[3:0], f), st_v[ST_TAKEN])
			pc = pc + (cond_ok(i[3:0], f) ? 32'h10 : 32'h2);
			apb(1'b0, OFF_PC, 32'h0);
			`CHK("branch pc", pc, rd_v)
			pc = rd_v;
		end
		apb(1'b0, OFF_FLAGS, 32'h0);
		`CHK("flags kept by branches", 4'hf, rd_v[31:28])
		$display("test conditions done");
		alu(op_sub_s, 32'h5, 32'h5, 0, 4'h9, 32'h0, 4'h6);
		apb(1'b1, OFF_PC, 32'h100);
		exec(cmd(op_pc_addr, cc_al, 5, 0, 0, 0, 10'h3fc));
		apb(1'b0, reg_a(5), 32'h0);
		`CHK("pc-relative address", 32'h500, rd_v)
		exec(cmd(op_pc_addr, cc_al, 5, 0, 0, 0, 10'h3fe));
		`CHK("pc-relative refused", 1'b1, st_v[ST_REFUSED])
		exec(cmd(op_branch, cc_eq, 0, 0, 0, 0, 0));
		`CHK("branch on earlier flags", 1'b1, st_v[ST_TAKEN])
		apb(1'b0, OFF_FLAGS, 32'h0);
		`CHK("flags after address", 4'h6, rd_v[31:28])
		$display("test pc-relative done");
		apb(1'b1, reg_a(1), 32'h1000);
		apb(1'b1, OFF_SP, 32'h2000);
		mem(op_word_store, 0, 10'h07c, 0, 32'h107c, sz_word);
		mem(op_halfword_store, 0, 10'h03e, 0, 32'h103e, sz_half);
		mem(op_byte_store, 0, 10'h01f, 0, 32'h101f, sz_byte);
		mem(op_word_store, 1, 10'h3fc, 0, 32'h23fc, sz_word);
		mem(op_word_load, 0, 0, 0, 32'h1000, sz_word);
		mem(op_halfword_load, 0, 10'h03e, 0, 32'h103e, sz_half);
		mem(op_byte_load, 0, 10'h01f, 0, 32'h101f, sz_byte);
		mem(op_word_load, 1, 10'h3fc, 0, 32'h23fc, sz_word);
		mem(op_word_load, 0, 10'h080, ST_REFUSED, 32'h0, sz_word);
		mem(op_halfword_store, 0, 10'h03f, ST_REFUSED, 32'h0, sz_half);
		mem(op_byte_load, 0, 10'h020, ST_REFUSED, 32'h0, sz_byte);
		mem(op_byte_store, 1, 0, ST_REFUSED, 32'h0, sz_byte);
		apb(1'b1, reg_a(1), 32'h1002);
		mem(op_word_store, 0, 0, ST_FAULT, 32'h0, sz_word);
		mem(op_halfword_load, 0, 0, 0, 32'h1002, sz_half);
		apb(1'b1, reg_a(1), 32'h1001);
		mem(op_halfword_load, 0, 0, ST_FAULT, 32'h0, sz_half);
		mem(op_byte_load, 0, 0, 0, 32'h1001, sz_byte);
		apb(1'b0, OFF_FLAGS, 32'h0);
		`CHK("flags after memory", 4'h6, rd_v[31:28])
		$display("test memory done");
		stop_test();
	end
endmodule : exec_core_tb

// file: verification/mem_model.sv
// memory model: accepts load/store requests after a settable wait
`timescale 1ns/10ps
module mem_model
	import exec_pkg::*;
(
	input  wire logic       pclk,       // clock
	input  wire logic       presetn,    // reset, active low
	input  wire mem_req_s   mem_req,    // request fields
	input  wire logic       mem_valid,  // request pending
	input  wire logic [3:0] ack_delay,  // cycles before accept
	output logic            mem_ack,    // accept
	output logic [31:0]     mem_rdata,  // load data
	output int              acc_n,      // accepted requests
	output mem_req_s        last_req    // last accepted request
);
	logic [3:0] cnt_q;

	// load data is full width garbage above the lanes and toggles outside the accept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q     <= 4'h0;
			mem_ack   <= 1'b0;
			mem_rdata <= 32'h0;
		end else if (mem_valid && !mem_ack && cnt_q >= ack_delay) begin
			cnt_q     <= 4'h0;
			mem_ack   <= 1'b1;
			mem_rdata <= ~mem_req.addr ^ 32'h3c00_0000;
		end else begin
			cnt_q     <= (mem_valid && !mem_ack) ? cnt_q + 4'h1 : 4'h0;
			mem_ack   <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_n    <= 0;
			last_req <= '0;
		end else if (mem_valid && mem_ack) begin
			acc_n    <= acc_n + 1;
			last_req <= mem_req;
		end
	end
endmodule : mem_model
